//--- stoc_regs.sv
// self-test control, persistent interface config and axis offset registers
// assumes the serial front end delivers one-cycle rd/wr strobes on clock,
// and the nvm engine loads the image and accepts a one-cycle store pulse
//
// Functional notes
// - self-test bit 0 enables, resets zero
// - self-test bit 2 picks excitation sign
// - self-test bit 3 picks deflection amplitude
// - autoconfig plus spi bit disables i2c
// - watchdog select zero gives 1.25 ms
// - watchdog select one gives 40 ms
// - watchdog on data pin only in i2c
// - offset enable adds offsets to both paths
// - x offset 8-bit rw, nvm backed
// - y offset 8-bit rw, nvm backed
// - z offset 8-bit rw, nvm backed
// - config register nvm backed, upper four bits zero
// - command 0xa0 stores nvm, reads zero
`timescale 1ns/10ps
`default_nettype none
module stoc_regs
  import stoc_pkg::*;
#(
  parameter logic [stoc_pkg::WDT_CNT_W-1:0] WDT_SHORT_LIM =
    stoc_pkg::WDT_SHORT_CYC,
  parameter logic [stoc_pkg::WDT_CNT_W-1:0] WDT_LONG_LIM  =
    stoc_pkg::WDT_LONG_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire stoc_pkg::stoc_reg_req_t  reg_req,
  output var  logic [stoc_pkg::DATA_W-1:0] rd_data_ff,
  input  wire logic                     nvm_load_valid,
  input  wire stoc_pkg::stoc_nv_image_t nvm_load_image,
  input  wire logic                     nvm_prog_allow,
  input  wire logic                     nvm_busy,
  output var  logic                     nvm_store_ff,
  output var  stoc_pkg::stoc_nv_image_t nvm_store_image_ff,
  input  wire logic                     if_autoconfig,
  output var  logic                     i2c_enable_ff,
  input  wire logic                     serial_data_in_pin,
  output var  logic                     wdt_expire_ff,
  output var  logic                     self_test_en_ff,
  output var  logic                     self_test_pos_ff,
  output var  logic                     self_test_high_ff,
  input  wire logic                     filt_valid,
  input  wire stoc_pkg::stoc_acc_vec_t  filt_in,
  input  wire logic                     raw_valid,
  input  wire stoc_pkg::stoc_acc_vec_t  raw_in,
  output var  logic                     filt_valid_ff,
  output var  stoc_pkg::stoc_acc_vec_t  filt_out_ff,
  output var  logic                     raw_valid_ff,
  output var  stoc_pkg::stoc_acc_vec_t  raw_out_ff
);
  import stoc_pkg::*;

  if (WDT_SHORT_LIM < 2 || WDT_LONG_LIM < 2) begin : g_chk_min
    $error("watchdog limits must be at least two cycles");
  end
  if (WDT_LONG_LIM <= WDT_SHORT_LIM) begin : g_chk_order
    $error("long watchdog limit must exceed short limit");
  end

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [DATA_W-1:0]              self_test_ff;
  logic [DATA_W-1:0]              persistent_iface_config_ff;
  logic [NUM_AXES-1:0][OFF_W-1:0] offset_ff;
  logic                           sda_meta_ff;
  logic                           sda_sync_ff;
  logic [WDT_CNT_W-1:0]           wdt_cnt_ff;

  logic                           wr_st;
  logic                           wr_nv;
  logic [NUM_AXES-1:0]            wr_off;
  logic                           wr_prog;
  logic [DATA_W-1:0]              nxt_rd_data;
  logic [WDT_CNT_W-1:0]           wdt_limit;
  logic                           wdt_run;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    wr_st   = reg_req.wr && (reg_req.addr == ADDR_SELF_TEST);
    wr_nv   = reg_req.wr && (reg_req.addr == ADDR_PERSISTENT_IFACE_CONFIG);
    wr_off  = '0;
    wr_off[0] = reg_req.wr && (reg_req.addr == ADDR_OFF_X);
    wr_off[1] = reg_req.wr && (reg_req.addr == ADDR_OFF_Y);
    wr_off[2] = reg_req.wr && (reg_req.addr == ADDR_OFF_Z);
    // programming is refused unless the host opened the nvm for it
    wr_prog = reg_req.wr && (reg_req.addr == ADDR_CMD) &&
              (reg_req.wdata == CMD_NVM_PROG) &&
              nvm_prog_allow && !nvm_busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // self-test control
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      self_test_ff <= RST_SELF_TEST;
    end else if (wr_st) begin
      self_test_ff <= reg_req.wdata & SELF_TEST_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      self_test_en_ff   <= 1'b0;
      self_test_pos_ff  <= 1'b0;
      self_test_high_ff <= 1'b0;
    end else begin
      self_test_en_ff   <= self_test_ff[ST_EN_BIT];
      self_test_pos_ff  <= self_test_ff[ST_SIGN_BIT];
      self_test_high_ff <= self_test_ff[ST_AMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nvm backed registers: a host write in the load cycle wins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      persistent_iface_config_ff <= RST_PERSISTENT_IFACE_CONFIG;
    end else if (wr_nv) begin
      persistent_iface_config_ff <= reg_req.wdata & PERSISTENT_IFACE_CONFIG_MASK;
    end else if (nvm_load_valid) begin
      persistent_iface_config_ff <= nvm_load_image.persistent_iface_config & PERSISTENT_IFACE_CONFIG_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      offset_ff <= {NUM_AXES{RST_OFFSET}};
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        if (wr_off[i]) begin
          offset_ff[i] <= reg_req.wdata;
        end else if (nvm_load_valid) begin
          unique case (i)
            0: offset_ff[i] <= nvm_load_image.off_x;
            1: offset_ff[i] <= nvm_load_image.off_y;
            default: offset_ff[i] <= nvm_load_image.off_z;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nvm store request carries a snapshot of every backed register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nvm_store_ff       <= 1'b0;
      nvm_store_image_ff <= '0;
    end else begin
      nvm_store_ff <= wr_prog;
      if (wr_prog) begin
        nvm_store_image_ff.persistent_iface_config <= persistent_iface_config_ff;
        nvm_store_image_ff.off_x   <= offset_ff[0];
        nvm_store_image_ff.off_y   <= offset_ff[1];
        nvm_store_image_ff.off_z   <= offset_ff[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: one cycle latency, unmapped and command read as zero
  always_comb begin
    unique case (reg_req.addr)
      ADDR_SELF_TEST: nxt_rd_data = self_test_ff & SELF_TEST_MASK;
      ADDR_PERSISTENT_IFACE_CONFIG:   nxt_rd_data = persistent_iface_config_ff & PERSISTENT_IFACE_CONFIG_MASK;
      ADDR_OFF_X:     nxt_rd_data = offset_ff[0];
      ADDR_OFF_Y:     nxt_rd_data = offset_ff[1];
      ADDR_OFF_Z:     nxt_rd_data = offset_ff[2];
      ADDR_CMD:       nxt_rd_data = RST_RD_DATA;
      default:        nxt_rd_data = RST_RD_DATA;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_data_ff <= RST_RD_DATA;
    end else if (reg_req.rd) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interface selection
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      i2c_enable_ff <= 1'b1;
    end else begin
      i2c_enable_ff <= !(if_autoconfig && persistent_iface_config_ff[NV_SPI_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data pin synchroniser
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
    end else begin
      sda_meta_ff <= serial_data_in_pin;
      sda_sync_ff <= sda_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // i2c watchdog: a data line held low past the period frees the bus
  always_comb begin
    wdt_limit = persistent_iface_config_ff[NV_WDT_SEL_BIT] ? WDT_LONG_LIM
                                           : WDT_SHORT_LIM;
    wdt_run   = persistent_iface_config_ff[NV_WDT_EN_BIT] && i2c_enable_ff &&
                !sda_sync_ff;
  end

  // >= so that shortening the period mid-count still expires promptly
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wdt_cnt_ff    <= '0;
      wdt_expire_ff <= 1'b0;
    end else begin
      wdt_expire_ff <= 1'b0;
      if (!wdt_run) begin
        wdt_cnt_ff <= '0;
      end else if (wdt_cnt_ff >= wdt_limit - 1'b1) begin
        wdt_cnt_ff    <= '0;
        wdt_expire_ff <= 1'b1;
      end else begin
        wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // offset compensation on the filtered and unfiltered paths
  logic [NUM_AXES-1:0]            filt_vld;
  logic [NUM_AXES-1:0]            raw_vld;
  logic [NUM_AXES-1:0][ACC_W-1:0] filt_sum;
  logic [NUM_AXES-1:0][ACC_W-1:0] raw_sum;
  logic [NUM_AXES-1:0][ACC_W-1:0] filt_axes;
  logic [NUM_AXES-1:0][ACC_W-1:0] raw_axes;

  assign filt_axes = filt_in;
  assign raw_axes  = raw_in;

  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    stoc_offset_add #(
      .ACC_W (ACC_W),
      .OFF_W (OFF_W)
    ) u_filt (
      .clock        (clock),
      .rst_b        (rst_b),
      .add_en       (persistent_iface_config_ff[NV_OFF_EN_BIT]),
      .in_valid     (filt_valid),
      .sample       (filt_axes[a]),
      .offset       (offset_ff[a]),
      .out_valid_ff (filt_vld[a]),
      .sum_ff       (filt_sum[a])
    );
    stoc_offset_add #(
      .ACC_W (ACC_W),
      .OFF_W (OFF_W)
    ) u_raw (
      .clock        (clock),
      .rst_b        (rst_b),
      .add_en       (persistent_iface_config_ff[NV_OFF_EN_BIT]),
      .in_valid     (raw_valid),
      .sample       (raw_axes[a]),
      .offset       (offset_ff[a]),
      .out_valid_ff (raw_vld[a]),
      .sum_ff       (raw_sum[a])
    );
  end

  // the adders already end in flip-flops; these names expose them
  assign filt_valid_ff = filt_vld[0];
  assign raw_valid_ff  = raw_vld[0];
  assign filt_out_ff   = filt_sum;
  assign raw_out_ff    = raw_sum;

endmodule : stoc_regs
`default_nettype wire

//--- stoc_pkg.sv
// package for the self-test, offset and persistent config register bank
// assumes a 50 MHz core clock and an 8-bit address/data register port
package stoc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ACC_W     = 16;
  localparam int unsigned OFF_W     = 8;
  localparam int unsigned NUM_AXES  = 3;
  localparam int unsigned WDT_CNT_W = 22;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SELF_TEST = 8'h6d;
  localparam logic [ADDR_W-1:0] ADDR_PERSISTENT_IFACE_CONFIG   = 8'h70;
  localparam logic [ADDR_W-1:0] ADDR_OFF_X     = 8'h71;
  localparam logic [ADDR_W-1:0] ADDR_OFF_Y     = 8'h72;
  localparam logic [ADDR_W-1:0] ADDR_OFF_Z     = 8'h73;
  localparam logic [ADDR_W-1:0] ADDR_CMD       = 8'h7e;

  localparam logic [DATA_W-1:0] CMD_NVM_PROG   = 8'ha0;

  ////////////////////////////////////////////////////////////////////////
  // field positions and writable masks
  localparam int unsigned ST_EN_BIT      = 0;
  localparam int unsigned ST_SIGN_BIT    = 2;
  localparam int unsigned ST_AMP_BIT     = 3;
  localparam int unsigned NV_SPI_BIT     = 0;
  localparam int unsigned NV_WDT_SEL_BIT = 1;
  localparam int unsigned NV_WDT_EN_BIT  = 2;
  localparam int unsigned NV_OFF_EN_BIT  = 3;

  localparam logic [DATA_W-1:0] SELF_TEST_MASK = 8'h0d;
  localparam logic [DATA_W-1:0] PERSISTENT_IFACE_CONFIG_MASK   = 8'h0f;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] RST_SELF_TEST = 8'h00;
  localparam logic [DATA_W-1:0] RST_PERSISTENT_IFACE_CONFIG   = 8'h00;
  localparam logic [DATA_W-1:0] RST_OFFSET    = 8'h00;
  localparam logic [DATA_W-1:0] RST_RD_DATA   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // watchdog timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WDT_SHORT_NS  = 1250000;
  localparam int unsigned WDT_LONG_NS   = 40000000;
  localparam logic [WDT_CNT_W-1:0] WDT_SHORT_CYC =
    WDT_CNT_W'(WDT_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [WDT_CNT_W-1:0] WDT_LONG_CYC  =
    WDT_CNT_W'(WDT_LONG_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } stoc_reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] persistent_iface_config;
    logic [DATA_W-1:0] off_x;
    logic [DATA_W-1:0] off_y;
    logic [DATA_W-1:0] off_z;
  } stoc_nv_image_t;

  typedef struct packed {
    logic [ACC_W-1:0] z;
    logic [ACC_W-1:0] y;
    logic [ACC_W-1:0] x;
  } stoc_acc_vec_t;

endpackage : stoc_pkg

//--- stoc_offset_add.sv
// one axis of offset compensation: signed sample plus signed offset
// assumes sample and offset are two's complement on the same clock
`timescale 1ns/10ps
`default_nettype none
module stoc_offset_add #(
  parameter int unsigned ACC_W = 16,
  parameter int unsigned OFF_W = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             add_en,
  input  wire logic             in_valid,
  input  wire logic [ACC_W-1:0] sample,
  input  wire logic [OFF_W-1:0] offset,
  output var  logic             out_valid_ff,
  output var  logic [ACC_W-1:0] sum_ff
);

  if (OFF_W > ACC_W) begin : g_chk
    $error("offset wider than sample");
  end

  logic [ACC_W:0]   ext_sum;
  logic [ACC_W-1:0] nxt_sum;

  ////////////////////////////////////////////////////////////////////////
  // saturate rather than wrap so a large offset cannot flip the sign
  always_comb begin
    ext_sum = {sample[ACC_W-1], sample} +
              {{(ACC_W+1-OFF_W){offset[OFF_W-1]}}, offset};
    if (!add_en) begin
      nxt_sum = sample;
    end else if (ext_sum[ACC_W] != ext_sum[ACC_W-1]) begin
      nxt_sum = {ext_sum[ACC_W], {(ACC_W-1){~ext_sum[ACC_W]}}};
    end else begin
      nxt_sum = ext_sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
      sum_ff       <= '0;
    end else begin
      out_valid_ff <= in_valid;
      if (in_valid) begin
        sum_ff <= nxt_sum;
      end
    end
  end

endmodule : stoc_offset_add
`default_nettype wire

//--- stoc_regs_chk.sv
// assertions for the self-test, config and offset register bank
// assumes it is bound onto stoc_regs and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module stoc_regs_chk
#(
  parameter logic [stoc_pkg::WDT_CNT_W-1:0] WDT_SHORT_LIM = 8,
  parameter logic [stoc_pkg::WDT_CNT_W-1:0] WDT_LONG_LIM  = 20
) (
  input wire logic                        clock,
  input wire logic                        rst_b,
  input wire stoc_pkg::stoc_reg_req_t     reg_req,
  input wire logic [stoc_pkg::DATA_W-1:0] rd_data_ff,
  input wire logic                        nvm_prog_allow,
  input wire logic                        nvm_busy,
  input wire logic                        nvm_store_ff,
  input wire logic                        if_autoconfig,
  input wire logic                        i2c_enable_ff,
  input wire logic                        wdt_expire_ff,
  input wire logic                        self_test_en_ff,
  input wire logic                        self_test_pos_ff,
  input wire logic                        self_test_high_ff
);
  import stoc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic                 st_wr;
  logic                 prog_cmd;
  logic [WDT_CNT_W-1:0] gap_ff;
  assign st_wr = reg_req.wr && reg_req.addr == ADDR_SELF_TEST;
  assign prog_cmd = reg_req.wr && reg_req.addr == ADDR_CMD &&
    reg_req.wdata == CMD_NVM_PROG && nvm_prog_allow && !nvm_busy;
  // cycles since the last timeout pulse, saturating so it never wraps
  always_ff @(posedge clock) begin
    if (!rst_b) gap_ff <= '0;
    else if (wdt_expire_ff) gap_ff <= WDT_CNT_W'(1);
    else if (gap_ff != '1) gap_ff <= gap_ff + 1'b1;
  end
  ////////////////////////////////////////
  property p_st_en;
    st_wr ##1 !st_wr |=>
      self_test_en_ff == $past(reg_req.wdata[ST_EN_BIT], 2);
  endproperty
  a_st_en: assert property (p_st_en)
    else $error("self-test enable wrong");
  property p_st_sign;
    st_wr ##1 !st_wr |=>
      self_test_pos_ff == $past(reg_req.wdata[ST_SIGN_BIT], 2);
  endproperty
  a_st_sign: assert property (p_st_sign)
    else $error("self-test sign wrong");
  property p_st_amp;
    st_wr ##1 !st_wr |=>
      self_test_high_ff == $past(reg_req.wdata[ST_AMP_BIT], 2);
  endproperty
  a_st_amp: assert property (p_st_amp)
    else $error("self-test amplitude wrong");
  property p_i2c;
    !if_autoconfig |=> i2c_enable_ff;
  endproperty
  a_i2c: assert property (p_i2c)
    else $error("i2c disabled outside autoconfig");
  property p_wdt_off;
    !i2c_enable_ff [*2] |=> !wdt_expire_ff;
  endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("watchdog fired with i2c off");
  property p_wdt_gap;
    wdt_expire_ff |-> gap_ff >= WDT_SHORT_LIM;
  endproperty
  a_wdt_gap: assert property (p_wdt_gap)
    else $error("watchdog fired too early");
  property p_store;
    prog_cmd |=> nvm_store_ff;
  endproperty
  a_store: assert property (p_store)
    else $error("store request missing");
  property p_nostore;
    !prog_cmd |=> !nvm_store_ff;
  endproperty
  a_nostore: assert property (p_nostore)
    else $error("store without a valid command");
  property p_cmd_rd;
    reg_req.rd && reg_req.addr == ADDR_CMD |=> rd_data_ff == 8'h00;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd)
    else $error("command register read nonzero");
  property p_rsv;
    reg_req.rd && reg_req.addr == ADDR_PERSISTENT_IFACE_CONFIG |=>
      (rd_data_ff & ~PERSISTENT_IFACE_CONFIG_MASK) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved config bits set");
  c_store: cover property (nvm_store_ff);
  c_spi: cover property (!i2c_enable_ff);
  c_long: cover property (wdt_expire_ff && gap_ff == WDT_LONG_LIM);
endmodule : stoc_regs_chk
`default_nettype wire

//--- stoc_host.sv
// host processor model: turns bench commands into one-cycle strobes
// assumes commands are offered just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module stoc_host (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    cmd_v,
  input  wire stoc_pkg::stoc_reg_req_t cmd,
  input  wire logic                    prog_en,
  output var  stoc_pkg::stoc_reg_req_t req_ff,
  output var  logic                    allow_ff
);
  import stoc_pkg::*;
  // a held cmd_v repeats the access, so each cycle is one whole access
  always_ff @(posedge clock) begin
    if (!rst_b) req_ff <= '0;
    else req_ff <= cmd_v ? cmd : '0;
  end
  // programming enable is registered like the command, so both reach the design on the same edge
  always_ff @(posedge clock) begin
    if (!rst_b) allow_ff <= 1'b0;
    else allow_ff <= prog_en;
  end
endmodule : stoc_host
`default_nettype wire

//--- stoc_tb.sv
// self-checking bench for the self-test, config and offset registers
// assumes the package, design, checker and host model compile first
`timescale 1ns/10ps
`default_nettype none
bind stoc_regs stoc_regs_chk #(.WDT_SHORT_LIM(WDT_SHORT_LIM),
  .WDT_LONG_LIM(WDT_LONG_LIM)) chk_u (.clock, .rst_b, .reg_req,
  .rd_data_ff, .nvm_prog_allow, .nvm_busy, .nvm_store_ff, .if_autoconfig,
  .i2c_enable_ff, .wdt_expire_ff, .self_test_en_ff, .self_test_pos_ff,
  .self_test_high_ff);
module testbench;
  import stoc_pkg::*;
  localparam logic [WDT_CNT_W-1:0] SHORT = 8;
  localparam logic [WDT_CNT_W-1:0] LONG  = 20;
  logic clock, rst_b, cmd_v, prog_en, nvm_prog_allow, nvm_busy;
  logic nvm_load_valid, nvm_store_ff, if_autoconfig, i2c_enable_ff;
  logic serial_data_in_pin, wdt_expire_ff, self_test_en_ff;
  logic self_test_pos_ff, self_test_high_ff, filt_valid, raw_valid;
  logic filt_valid_ff, raw_valid_ff, rd_seen;
  stoc_reg_req_t  cmd, reg_req;
  stoc_nv_image_t nvm_load_image, nvm_store_image_ff;
  stoc_acc_vec_t  filt_in, raw_in, filt_out_ff, raw_out_ff;
  logic [7:0]     rd_data_ff, d;
  logic [7:0]     sh [4];
  logic [7:0]     adr [7];
  logic [47:0]    rdq[$], fq[$], rq[$], sq[$];
  int             errors, checks, n, seed;
  stoc_host host_u (.clock, .rst_b, .cmd_v, .cmd, .prog_en,
    .req_ff(reg_req), .allow_ff(nvm_prog_allow));
  stoc_regs #(.WDT_SHORT_LIM(SHORT), .WDT_LONG_LIM(LONG)) dut_u (.clock,
    .rst_b, .reg_req, .rd_data_ff, .nvm_load_valid, .nvm_load_image,
    .nvm_prog_allow, .nvm_busy, .nvm_store_ff, .nvm_store_image_ff,
    .if_autoconfig, .i2c_enable_ff, .serial_data_in_pin, .wdt_expire_ff,
    .self_test_en_ff, .self_test_pos_ff, .self_test_high_ff, .filt_valid,
    .filt_in, .raw_valid, .raw_in, .filt_valid_ff, .filt_out_ff,
    .raw_valid_ff, .raw_out_ff);
  ////////////////////////////////////////
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  task automatic idle(input int k);
    cmd_v = 1'b0;
    repeat (k) tick();
  endtask : idle
  // one access; a read notes its expected data for the monitor
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    cmd_v = 1'b1;
    cmd = '{w, !w, a, w ? v : 8'h00};
    if (!w) rdq.push_back(48'(v));
    tick();
  endtask : acc
  task automatic wait_wdt(output int k);
    k = 0;
    while (wdt_expire_ff !== 1'b1 && k < 100) begin
      tick();
      k++;
    end
    if (k >= 100) begin
      errors++;
      end_sim();
    end
  endtask : wait_wdt
  function automatic logic [7:0] msk(input logic [7:0] a);
    if (a == ADDR_SELF_TEST) return SELF_TEST_MASK;
    if (a == ADDR_PERSISTENT_IFACE_CONFIG) return PERSISTENT_IFACE_CONFIG_MASK;
    return (a > ADDR_PERSISTENT_IFACE_CONFIG && a <= ADDR_OFF_Z) ? 8'hff : 8'h00;
  endfunction : msk
  function automatic logic [47:0] offs(input logic [47:0] v);
    logic signed [17:0] s;
    if (!sh[0][NV_OFF_EN_BIT]) return v;
    for (int i = 0; i < 3; i++) begin
      s = $signed(v[16*i +: 16]) + $signed(sh[i + 1]);
      if (s > 18'sh07fff) s = 18'sh07fff;
      if (s < 18'sh38000) s = 18'sh38000;
      v[16*i +: 16] = s[15:0];
    end
    return v;
  endfunction : offs
  function automatic logic [47:0] nx(ref logic [47:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction : nx
  ////////////////////////////////////////
  // results are matched against the oldest note of their own kind
  always @(posedge clock) begin
    rd_seen = reg_req.rd && rst_b;
    #1;
    if (rd_seen) chk(rd_data_ff, nx(rdq));
    if (filt_valid_ff === 1'b1) chk(filt_out_ff, nx(fq));
    if (raw_valid_ff === 1'b1) chk(raw_out_ff, nx(rq));
    if (nvm_store_ff === 1'b1) chk(nvm_store_image_ff, nx(sq));
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
  initial begin
    seed = 32'h73e9fc18;
    {errors, checks, rst_b, cmd_v, prog_en, nvm_busy, nvm_load_valid} = '0;
    {if_autoconfig, filt_valid, raw_valid, cmd, nvm_load_image} = '0;
    {filt_in, raw_in} = '0;
    sh = '{default: 8'h00};
    serial_data_in_pin = 1'b1;
    adr = '{8'h6d, 8'h70, 8'h71, 8'h72, 8'h73, 8'h7e, 8'h55};
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    foreach (adr[i]) acc(1'b0, adr[i], 8'h00);
    repeat (3) for (int i = 0; i < 7; i++) begin
      if (i == 5) continue;
      d = 8'($random(seed));
      acc(1'b1, adr[i], d);
      acc(1'b0, adr[i], d & msk(adr[i]));
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ADDR_SELF_TEST, {4'h0, i[2], i[1], 1'b0, i[0]});
      idle(2);
      d = {5'h00, self_test_high_ff, self_test_pos_ff, self_test_en_ff};
      chk(d, i[2:0]);
    end
    for (int i = 0; i < 4; i++) begin
      if_autoconfig = i[1];
      acc(1'b1, ADDR_PERSISTENT_IFACE_CONFIG, {7'h00, i[0]});
      idle(2);
      chk(i2c_enable_ff, !(i[1] & i[0]));
    end
    if_autoconfig = 1'b0;
    prog_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      sh[i] = 8'($random(seed));
      acc(1'b1, 8'(ADDR_PERSISTENT_IFACE_CONFIG + i), sh[i]);
      sh[i] = sh[i] & msk(8'(ADDR_PERSISTENT_IFACE_CONFIG + i));
    end
    sq.push_back({sh[0], sh[1], sh[2], sh[3]});
    acc(1'b1, ADDR_CMD, CMD_NVM_PROG);
    acc(1'b1, ADDR_CMD, 8'ha1);
    nvm_busy = 1'b1;
    acc(1'b1, ADDR_CMD, CMD_NVM_PROG);
    idle(1);
    {nvm_busy, prog_en} = 2'b00;
    acc(1'b1, ADDR_CMD, CMD_NVM_PROG);
    acc(1'b0, ADDR_CMD, 8'h00);
    nvm_load_image = $random(seed);
    nvm_load_valid = 1'b1;
    // drop cmd_v here, or the command read above is issued twice
    idle(1);
    nvm_load_valid = 1'b0;
    {sh[0], sh[1], sh[2], sh[3]} = nvm_load_image;
    sh[0] = sh[0] & PERSISTENT_IFACE_CONFIG_MASK;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 8'(ADDR_PERSISTENT_IFACE_CONFIG + i), sh[i]);
    end
    for (int k = 0; k < 2; k++) begin
      sh[0] = k[0] ? 8'h08 : 8'h00;
      acc(1'b1, ADDR_PERSISTENT_IFACE_CONFIG, sh[0]);
      idle(1);
      repeat (12) begin
        {filt_in, raw_in} = {$random(seed), $random(seed), $random(seed)};
        filt_in.x = 16'h7fff;
        raw_in.x = 16'h8000;
        {filt_valid, raw_valid} = 2'($random(seed));
        if (filt_valid) fq.push_back(offs(filt_in));
        if (raw_valid) rq.push_back(offs(raw_in));
        tick();
      end
      {filt_valid, raw_valid} = 2'b00;
    end
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, ADDR_PERSISTENT_IFACE_CONFIG, k[0] ? 8'h06 : 8'h04);
      serial_data_in_pin = 1'b0;
      idle(1);
      wait_wdt(n);
      idle(1);
      wait_wdt(n);
      chk(48'(n + 1), k[0] ? LONG : SHORT);
    end
    if_autoconfig = 1'b1;
    acc(1'b1, ADDR_PERSISTENT_IFACE_CONFIG, 8'h05);
    idle(30);
    // a note left over means an expected result never appeared
    n = rdq.size() + fq.size() + rq.size() + sq.size();
    chk(48'(n), 48'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
